// [logic/nuc_ctrl.sv]
`timescale 1ns/1ns
// Summary of operation
// - Unlock key register stores nothing
// - Erase enable selects erase outside data space, cleared after
// - Address high top bit reads one
// - Data high upper two bits read zero
// - Address low gives address bits 7:0
// - Address high gives bits 14:8
// - Data bytes carry program word bits
module nuc_ctrl (
   input wire logic clock,
   input wire logic sys_rst,
   // AXI4-Lite write address
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Memory array request
   output logic mem_req,
   output nuc_pkg::nuc_op_t mem_op,
   output logic mem_flash,
   output logic mem_config,
   output logic [14:0] mem_addr,
   output logic [13:0] mem_wdata,
   // Memory array completion
   input wire logic mem_done,
   input wire logic [13:0] mem_rdata
);

   // Captured write address and data
   logic aw_got;
   logic w_got;
   logic [4:0] aw_addr;
   logic [7:0] w_byte;
   logic w_lane0;
   // Write applied this cycle
   logic wr_fire;
   logic wr_mapped;
   // Per-register write strobes
   logic we_ctrl;
   logic we_key;
   logic we_other;
   logic we_al;
   logic we_ah;
   logic we_dl;
   logic we_dh;
   // Control and status bits
   logic flash_space_select;
   logic config_space_select;
   logic latch_only_load;
   logic erase_enable;
   logic write_fault_flag;
   logic write_enable_bit;
   logic write_start;
   logic read_start;
   logic [7:0] ctrl_read;
   // Unlock detector output
   logic unlock_armed;
   // Holding register read values
   logic [7:0] nvm_address_low;
   logic [7:0] nvm_address_high;
   logic [7:0] nvm_data_low;
   logic [7:0] nvm_data_high;
   // Start decisions for this write
   logic start_write;
   logic refuse_write;
   logic start_read;
   // Read completion loads the data bytes
   logic read_done;
   logic [7:0] rd_byte;
   logic rd_mapped;

   assign wr_fire = aw_got && w_got && !s_axi_bvalid;
   assign wr_mapped = (aw_addr <= nuc_pkg::OFS_DATA_HIGH)
                      && (aw_addr[1:0] == 2'h0);
   assign we_ctrl = wr_fire && w_lane0
                    && (aw_addr == nuc_pkg::OFS_CONTROL_STATUS);
   assign we_key = wr_fire && w_lane0
                   && (aw_addr == nuc_pkg::OFS_UNLOCK_KEY);
   assign we_other = wr_fire && !we_key;
   assign we_al = wr_fire && w_lane0
                  && (aw_addr == nuc_pkg::OFS_ADDRESS_LOW);
   assign we_ah = wr_fire && w_lane0
                  && (aw_addr == nuc_pkg::OFS_ADDRESS_HIGH);
   assign we_dl = wr_fire && w_lane0
                  && (aw_addr == nuc_pkg::OFS_DATA_LOW);
   assign we_dh = wr_fire && w_lane0
                  && (aw_addr == nuc_pkg::OFS_DATA_HIGH);

   // Write address channel, one outstanding
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         aw_got <= 1'b0;
         aw_addr <= 5'h00;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_got <= 1'b1;
         aw_addr <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
         aw_got <= 1'b0;
      end else if (!aw_got && !s_axi_bvalid) begin
         // Reopen only once the response has gone
         s_axi_awready <= 1'b1;
      end
   end

   // Write data channel, taken independently of the address
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         w_got <= 1'b0;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_got <= 1'b1;
         w_byte <= s_axi_wdata[7:0];
         w_lane0 <= s_axi_wstrb[0];
         s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
         w_got <= 1'b0;
      end else if (!w_got && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   // Write response follows both halves
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= nuc_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? nuc_pkg::RESP_OKAY
                                  : nuc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Key writes feed the detector only
   nuc_unlock u_unlock (
      .clock(clock),
      .sys_rst(sys_rst),
      .key_write(we_key),
      .key_value(w_byte),
      .other_write(we_other),
      .armed(unlock_armed)
   );

   // Start only with enable and unlock
   assign start_write = we_ctrl && w_byte[nuc_pkg::BIT_WRITE_START]
                        && !write_start && !read_start
                        && unlock_armed
                        && w_byte[nuc_pkg::BIT_WRITE_ENABLE];
   assign refuse_write = we_ctrl && w_byte[nuc_pkg::BIT_WRITE_START]
                         && !write_start && !start_write;
   // Read start is ignored while an operation runs
   assign start_read = we_ctrl && w_byte[nuc_pkg::BIT_READ_START]
                       && !write_start && !read_start && !start_write;
   assign read_done = read_start && mem_done;

   // Space selects and plain mode bits
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         flash_space_select <= 1'b0;
         config_space_select <= 1'b0;
         latch_only_load <= 1'b0;
         write_enable_bit <= 1'b0;
      end else if (we_ctrl) begin
         flash_space_select <= w_byte[nuc_pkg::BIT_FLASH_SPACE];
         config_space_select <= w_byte[nuc_pkg::BIT_CONFIG_SPACE];
         latch_only_load <= w_byte[nuc_pkg::BIT_LATCH_ONLY];
         write_enable_bit <= w_byte[nuc_pkg::BIT_WRITE_ENABLE];
      end
   end

   // Hardware clears erase enable after erase
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         erase_enable <= 1'b0;
      end else if (we_ctrl) begin
         erase_enable <= w_byte[nuc_pkg::BIT_ERASE_ENABLE];
      end else if (write_start && mem_done
                   && mem_op == nuc_pkg::NUC_OP_ERASE) begin
         erase_enable <= 1'b0;
      end
   end

   // Fault flag: a refused start sets it, set beats software clear
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         write_fault_flag <= 1'b0;
      end else if (refuse_write) begin
         write_fault_flag <= 1'b1;
      end else if (we_ctrl) begin
         write_fault_flag <= w_byte[nuc_pkg::BIT_WRITE_FAULT];
      end
   end

   // Start bits: software sets only, hardware clears on completion
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         write_start <= 1'b0;
         read_start <= 1'b0;
      end else begin
         if (start_write) begin
            write_start <= 1'b1;
         end else if (mem_done) begin
            write_start <= 1'b0;
         end
         if (start_read) begin
            read_start <= 1'b1;
         end else if (mem_done) begin
            read_start <= 1'b0;
         end
      end
   end

   assign ctrl_read = {flash_space_select, config_space_select,
                       latch_only_load, erase_enable, write_fault_flag,
                       write_enable_bit, write_start, read_start};

   nuc_reg8 #(
      .WMASK(nuc_pkg::FULL_WMASK),
      .ONES(nuc_pkg::NO_ONES)
   ) u_addr_low (
      .clock(clock),
      .sys_rst(sys_rst),
      .sw_we(we_al),
      .sw_data(w_byte),
      .hw_we(1'b0),
      .hw_data(8'h00),
      .value(nvm_address_low)
   );

   nuc_reg8 #(
      .WMASK(nuc_pkg::ADDR_HIGH_WMASK),
      .ONES(nuc_pkg::ADDR_HIGH_ONES)
   ) u_addr_high (
      .clock(clock),
      .sys_rst(sys_rst),
      .sw_we(we_ah),
      .sw_data(w_byte),
      .hw_we(1'b0),
      .hw_data(8'h00),
      .value(nvm_address_high)
   );

   // Low data byte, loaded by reads
   nuc_reg8 #(
      .WMASK(nuc_pkg::FULL_WMASK),
      .ONES(nuc_pkg::NO_ONES)
   ) u_data_low (
      .clock(clock),
      .sys_rst(sys_rst),
      .sw_we(we_dl),
      .sw_data(w_byte),
      .hw_we(read_done),
      .hw_data(mem_rdata[7:0]),
      .value(nvm_data_low)
   );

   // Six bits stored, upper two read zero
   nuc_reg8 #(
      .WMASK(nuc_pkg::DATA_HIGH_WMASK),
      .ONES(nuc_pkg::NO_ONES)
   ) u_data_high (
      .clock(clock),
      .sys_rst(sys_rst),
      .sw_we(we_dh),
      .sw_data(w_byte),
      .hw_we(read_done),
      .hw_data({2'h0, mem_rdata[13:8]}),
      .value(nvm_data_high)
   );

   // Memory request: one-cycle pulse, payload held until next start
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mem_req <= 1'b0;
         mem_op <= nuc_pkg::NUC_OP_READ;
         mem_flash <= 1'b0;
         mem_config <= 1'b0;
         mem_addr <= 15'h0000;
         mem_wdata <= 14'h0000;
      end else begin
         mem_req <= start_write || start_read;
         if (start_write || start_read) begin
            // Modes come from the byte being written
            mem_flash <= w_byte[nuc_pkg::BIT_FLASH_SPACE];
            mem_config <= w_byte[nuc_pkg::BIT_CONFIG_SPACE];
            mem_addr <= {nvm_address_high[6:0], nvm_address_low};
            mem_wdata <= {nvm_data_high[5:0], nvm_data_low};
            if (start_read) begin
               mem_op <= nuc_pkg::NUC_OP_READ;
            // Erase when enabled outside data space
            end else if (w_byte[nuc_pkg::BIT_ERASE_ENABLE]
                         && (w_byte[nuc_pkg::BIT_CONFIG_SPACE]
                             || w_byte[nuc_pkg::BIT_FLASH_SPACE])) begin
               mem_op <= nuc_pkg::NUC_OP_ERASE;
            end else if (w_byte[nuc_pkg::BIT_LATCH_ONLY]
                         && !w_byte[nuc_pkg::BIT_CONFIG_SPACE]
                         && w_byte[nuc_pkg::BIT_FLASH_SPACE]) begin
               // Latch-only loads only fill the program latches
               mem_op <= nuc_pkg::NUC_OP_LATCH;
            end else begin
               mem_op <= nuc_pkg::NUC_OP_WRITE;
            end
         end
      end
   end

   // Read mux; the key word reads zero since nothing is stored
   always_comb begin
      rd_byte = 8'h00;
      rd_mapped = (s_axi_araddr[1:0] == 2'h0);
      case (s_axi_araddr)
         nuc_pkg::OFS_CONTROL_STATUS: rd_byte = ctrl_read;
         nuc_pkg::OFS_UNLOCK_KEY: rd_byte = 8'h00;
         nuc_pkg::OFS_ADDRESS_LOW: rd_byte = nvm_address_low;
         nuc_pkg::OFS_ADDRESS_HIGH: rd_byte = nvm_address_high;
         nuc_pkg::OFS_DATA_LOW: rd_byte = nvm_data_low;
         nuc_pkg::OFS_DATA_HIGH: rd_byte = nvm_data_high;
         default: rd_mapped = 1'b0;
      endcase
   end

   // Read channel: answer one cycle after the address is taken
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= nuc_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rd_byte};
         s_axi_rresp <= rd_mapped ? nuc_pkg::RESP_OKAY
                                  : nuc_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule // nuc_ctrl

// [logic/nuc_pkg.sv]
package nuc_pkg;

   // Byte offsets of the register words on the AXI4-Lite bus
   localparam logic [4:0] OFS_CONTROL_STATUS = 5'h00;
   localparam logic [4:0] OFS_UNLOCK_KEY = 5'h04;
   localparam logic [4:0] OFS_ADDRESS_LOW = 5'h08;
   localparam logic [4:0] OFS_ADDRESS_HIGH = 5'h0c;
   localparam logic [4:0] OFS_DATA_LOW = 5'h10;
   localparam logic [4:0] OFS_DATA_HIGH = 5'h14;

   // Bit positions in the control and status byte
   localparam int BIT_FLASH_SPACE = 7;
   localparam int BIT_CONFIG_SPACE = 6;
   localparam int BIT_LATCH_ONLY = 5;
   localparam int BIT_ERASE_ENABLE = 4;
   localparam int BIT_WRITE_FAULT = 3;
   localparam int BIT_WRITE_ENABLE = 2;
   localparam int BIT_WRITE_START = 1;
   localparam int BIT_READ_START = 0;

   // Unlock key bytes, in the order they must arrive
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;

   // Implemented bits and forced bits of the holding registers
   localparam logic [7:0] ADDR_HIGH_WMASK = 8'h7f;
   localparam logic [7:0] ADDR_HIGH_ONES = 8'h80;
   localparam logic [7:0] DATA_HIGH_WMASK = 8'h3f;
   localparam logic [7:0] FULL_WMASK = 8'hff;
   localparam logic [7:0] NO_ONES = 8'h00;

   // Values after reset
   localparam logic [7:0] RESET_BYTE = 8'h00;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Operation handed to the memory arrays
   typedef enum logic [1:0] {
      NUC_OP_READ,
      NUC_OP_WRITE,
      NUC_OP_ERASE,
      NUC_OP_LATCH
   } nuc_op_t;

endpackage

// [logic/nuc_reg8.sv]
`timescale 1ns/1ns
// Holding byte with software and hardware write ports
module nuc_reg8 #(
   parameter logic [7:0] WMASK = 8'hff,
   parameter logic [7:0] ONES = 8'h00
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic sw_we,
   input wire logic [7:0] sw_data,
   input wire logic hw_we,
   input wire logic [7:0] hw_data,
   output logic [7:0] value
);

   // Only implemented bits are stored
   logic [7:0] store;

   // Hardware load wins: it lands the result of a finished read
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         store <= nuc_pkg::RESET_BYTE;
      end else if (hw_we) begin
         store <= hw_data & WMASK;
      end else if (sw_we) begin
         store <= sw_data & WMASK;
      end
   end

   // Unimplemented bits read as the fixed pattern
   assign value = (store & WMASK) | ONES;

endmodule // nuc_reg8

// [logic/nuc_unlock.sv]
`timescale 1ns/1ns
// Two-byte unlock sequence detector, holds no register content
module nuc_unlock (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic key_write,
   input wire logic [7:0] key_value,
   input wire logic other_write,
   output logic armed
);

   typedef enum logic [1:0] {
      NUC_LOCKED,
      NUC_HALF,
      NUC_ARMED
   } nuc_lock_t;

   // Sequence position
   nuc_lock_t state;

   // Key bytes only steer this machine
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state <= NUC_LOCKED;
      end else if (key_write) begin
         case (state)
            NUC_HALF: begin
               if (key_value == nuc_pkg::KEY_SECOND) begin
                  state <= NUC_ARMED;
               end else if (key_value == nuc_pkg::KEY_FIRST) begin
                  state <= NUC_HALF;
               end else begin
                  state <= NUC_LOCKED;
               end
            end
            // Any state restarts on a fresh first byte
            default: begin
               if (key_value == nuc_pkg::KEY_FIRST) begin
                  state <= NUC_HALF;
               end else begin
                  state <= NUC_LOCKED;
               end
            end
         endcase
      end else if (other_write) begin
         // Any other register write breaks the sequence
         state <= NUC_LOCKED;
      end
   end

   assign armed = (state == NUC_ARMED);

endmodule // nuc_unlock

// [sim/nuc_ctrl_props.sv]
`timescale 1ns/1ns
// Port-level checker for the flash access control block
module nuc_ctrl_props (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic mem_req,
   input wire nuc_pkg::nuc_op_t mem_op,
   input wire logic mem_flash,
   input wire logic mem_config,
   input wire logic [14:0] mem_addr,
   input wire logic [13:0] mem_wdata,
   input wire logic mem_done,
   input wire logic [13:0] mem_rdata
);
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   // Shadow bytes rebuilt from bus traffic, so outputs can be judged
   logic [4:0] aw_q;
   logic [7:0] wd_q, sh_al, sh_ah, sh_dl, sh_dh;
   logic ws_q;
   // Capture each write, apply it when its response is taken
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         aw_q <= 5'h00;
         wd_q <= 8'h00;
         ws_q <= 1'b0;
         sh_al <= 8'h00;
         sh_ah <= 8'h00;
         sh_dl <= 8'h00;
         sh_dh <= 8'h00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) begin
            wd_q <= s_axi_wdata[7:0];
            ws_q <= s_axi_wstrb[0];
         end
         if (s_axi_bvalid && s_axi_bready && ws_q) begin
            case (aw_q)
               nuc_pkg::OFS_ADDRESS_LOW: sh_al <= wd_q;
               nuc_pkg::OFS_ADDRESS_HIGH: sh_ah <= wd_q;
               nuc_pkg::OFS_DATA_LOW: sh_dl <= wd_q;
               nuc_pkg::OFS_DATA_HIGH: sh_dh <= wd_q;
               default: ;
            endcase
         end
         // A finished read reloads the data bytes
         if (mem_done && mem_op == nuc_pkg::NUC_OP_READ) begin
            sh_dl <= mem_rdata[7:0];
            sh_dh <= {2'h0, mem_rdata[13:8]};
         end
      end
   end
   // Read request taken at one address
   sequence ar_take(logic [4:0] a);
      s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
   endsequence
   a_key_reads_zero: assert property (
      ar_take(nuc_pkg::OFS_UNLOCK_KEY) |=> s_axi_rvalid && s_axi_rdata == '0)
      else $error("unlock key word read back nonzero");
   a_erase_space: assert property (
      mem_req && mem_op == nuc_pkg::NUC_OP_ERASE |-> mem_flash || mem_config)
      else $error("erase issued to data space");
   a_addr_top_one: assert property (
      ar_take(nuc_pkg::OFS_ADDRESS_HIGH) |=>
         s_axi_rvalid && s_axi_rdata[31:7] == 25'h1)
      else $error("address high top bit not one");
   a_data_top_zero: assert property (
      ar_take(nuc_pkg::OFS_DATA_HIGH) |=>
         s_axi_rvalid && s_axi_rdata[31:6] == 26'h0)
      else $error("data high upper bits not zero");
   a_addr_low: assert property (
      mem_req |-> mem_addr[7:0] == sh_al)
      else $error("low address byte wrong");
   a_addr_high: assert property (
      mem_req |-> mem_addr[14:8] == sh_ah[6:0])
      else $error("high address bits wrong");
   a_data_word: assert property (
      mem_req |-> mem_wdata == {sh_dh[5:0], sh_dl})
      else $error("program word wrong");
   a_start_on_write: assert property (
      mem_req |-> $rose(s_axi_bvalid))
      else $error("memory request without control write");
   a_mem_pulse: assert property (mem_req |=> !mem_req)
      else $error("memory request longer than one cycle");
   a_resp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
endmodule // nuc_ctrl_props

bind nuc_ctrl nuc_ctrl_props nuc_ctrl_props_i (
   .clock(clock),
   .sys_rst(sys_rst),
   .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid),
   .mem_req(mem_req),
   .mem_op(mem_op),
   .mem_flash(mem_flash),
   .mem_config(mem_config),
   .mem_addr(mem_addr),
   .mem_wdata(mem_wdata),
   .mem_done(mem_done),
   .mem_rdata(mem_rdata)
);

// [sim/nuc_ctrl_tb_top.sv]
`timescale 1ns/1ns
// Self-checking bench for the flash access control block
module nuc_ctrl_tb_top;
   logic clock, sys_rst;
   logic [4:0] aw_a, ar_a;
   logic [31:0] w_d, r_d;
   logic [3:0] w_s;
   logic [1:0] b_resp, r_resp;
   logic aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
   logic mem_req, mem_flash, mem_config, mem_done;
   nuc_pkg::nuc_op_t mem_op;
   logic [14:0] mem_addr;
   logic [13:0] mem_wdata, mem_rdata;
   // Expected results, oldest first; top bit zero marks a real note
   logic [42:0] rq[$];
   logic [2:0] bq[$];
   logic [33:0] mq[$];
   int err_count, checks, cyc;
   logic [7:0] al, ah, dl, dh;
   logic [7:0] cv [6] = '{8'h86, 8'h96, 8'ha6, 8'h16, 8'h56, 8'h46};

   nuc_ctrl nuc_ctrl_i (.clock(clock), .sys_rst(sys_rst),
      .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
      .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v),
      .s_axi_wready(w_r), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
      .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
      .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
      .s_axi_rvalid(r_v), .s_axi_rready(r_r), .mem_req(mem_req),
      .mem_op(mem_op), .mem_flash(mem_flash), .mem_config(mem_config),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_done(mem_done),
      .mem_rdata(mem_rdata));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Bus write; the response is judged by the watcher
   task automatic wr(input logic [4:0] a, input logic [7:0] d,
                     input logic [1:0] r);
      bq.push_back({1'b0, r});
      aw_a <= a;
      w_d <= {24'($urandom), d};
      w_s <= {3'($urandom), 1'b1};
      aw_v <= 1'b1;
      w_v <= 1'b1;
      do begin
         @(posedge clock);
         if (aw_v && aw_r) aw_v <= 1'b0;
         if (w_v && w_r) w_v <= 1'b0;
         if (!b_r) b_r <= b_v;
      end while (!(b_v && b_r));
      b_r <= 1'b0;
      @(posedge clock);
   endtask

   // Bus read; in the low byte only the bits in the mask are compared
   task automatic rd(input logic [4:0] a, input logic [7:0] m,
                     input logic [1:0] r, input logic [7:0] d);
      rq.push_back({1'b0, m, r, 24'h0, d & m});
      ar_a <= a;
      ar_v <= 1'b1;
      r_r <= 1'b1;
      do begin
         @(posedge clock);
         if (ar_v && ar_r) ar_v <= 1'b0;
      end while (!r_v);
      r_r <= 1'b0;
      @(posedge clock);
   endtask

   // Array finishes the running operation a few cycles later
   task automatic done(input logic [13:0] v);
      repeat (3) @(posedge clock);
      mem_done <= 1'b1;
      mem_rdata <= v;
      @(posedge clock);
      mem_done <= 1'b0;
   endtask

   task automatic unlock();
      wr(nuc_pkg::OFS_UNLOCK_KEY, nuc_pkg::KEY_FIRST, nuc_pkg::RESP_OKAY);
      wr(nuc_pkg::OFS_UNLOCK_KEY, nuc_pkg::KEY_SECOND, nuc_pkg::RESP_OKAY);
   endtask

   // Watcher: an empty queue yields all ones, which never matches
   always @(posedge clock) begin : watch
      logic [42:0] e;
      logic [33:0] m;
      logic [2:0] b;
      if (r_v && r_r) begin
         checks++;
         e = rq.size() ? rq.pop_front() : '1;
         if ({1'b0, r_resp, r_d & {24'hffffff, e[41:34]}} !==
             {e[42], e[33:0]}) begin
            err_count++;
            $display("[FAIL] %0t read got %h", $time, r_d);
         end
      end
      if (b_v && b_r) begin
         checks++;
         b = bq.size() ? bq.pop_front() : '1;
         if ({1'b0, b_resp} !== b) begin
            err_count++;
            $display("[FAIL] %0t write response %h", $time, b_resp);
         end
      end
      if (mem_req) begin
         checks++;
         m = mq.size() ? mq.pop_front() : '1;
         if ({1'b0, mem_op, mem_flash, mem_config, mem_addr, mem_wdata} !== m)
         begin
            err_count++;
            $display("[FAIL] %0t memory request wrong", $time);
         end
      end
   end

   // Hang guard
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         $display("[FAIL] %0t run did not finish", $time);
         close_out();
      end
   end

   initial begin : main
      nuc_pkg::nuc_op_t op;
      logic [7:0] c;
      logic [13:0] v;
      void'($urandom(32'hdd41));
      {aw_a, ar_a, w_d, w_s} = '0;
      {aw_v, w_v, b_r, ar_v, r_r, mem_done} = '0;
      mem_rdata = 14'h0000;
      sys_rst = 1'b1;
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      // Reset contents and unmapped places
      rd(nuc_pkg::OFS_CONTROL_STATUS, '1, nuc_pkg::RESP_OKAY, 8'h00);
      rd(nuc_pkg::OFS_UNLOCK_KEY, '1, nuc_pkg::RESP_OKAY, 8'h00);
      rd(nuc_pkg::OFS_ADDRESS_HIGH, '1, nuc_pkg::RESP_OKAY, 8'h80);
      rd(nuc_pkg::OFS_DATA_HIGH, '1, nuc_pkg::RESP_OKAY, 8'h00);
      rd(5'h18, '1, nuc_pkg::RESP_SLVERR, 8'h00);
      rd(5'h02, '1, nuc_pkg::RESP_SLVERR, 8'h00);
      wr(5'h1c, 8'h5a, nuc_pkg::RESP_SLVERR);
      // Holding bytes with random contents
      {al, ah, dl, dh} = 32'($urandom);
      wr(nuc_pkg::OFS_ADDRESS_LOW, al, nuc_pkg::RESP_OKAY);
      wr(nuc_pkg::OFS_ADDRESS_HIGH, ah, nuc_pkg::RESP_OKAY);
      wr(nuc_pkg::OFS_DATA_LOW, dl, nuc_pkg::RESP_OKAY);
      wr(nuc_pkg::OFS_DATA_HIGH, dh, nuc_pkg::RESP_OKAY);
      rd(nuc_pkg::OFS_ADDRESS_LOW, '1, nuc_pkg::RESP_OKAY, al);
      rd(nuc_pkg::OFS_ADDRESS_HIGH, '1, nuc_pkg::RESP_OKAY, ah | 8'h80);
      rd(nuc_pkg::OFS_DATA_LOW, '1, nuc_pkg::RESP_OKAY, dl);
      rd(nuc_pkg::OFS_DATA_HIGH, '1, nuc_pkg::RESP_OKAY, dh & 8'h3f);
      wr(nuc_pkg::OFS_UNLOCK_KEY, 8'h55, nuc_pkg::RESP_OKAY);
      rd(nuc_pkg::OFS_UNLOCK_KEY, '1, nuc_pkg::RESP_OKAY, 8'h00);
      // Every space and mode after a proper unlock
      for (int i = 0; i < 6; i++) begin
         c = cv[i];
         op = (c[4] && (c[7] || c[6])) ? nuc_pkg::NUC_OP_ERASE :
              (c[5] && c[7] && !c[6]) ? nuc_pkg::NUC_OP_LATCH :
              nuc_pkg::NUC_OP_WRITE;
         mq.push_back({1'b0, op, c[7], c[6], ah[6:0], al, dh[5:0], dl});
         unlock();
         wr(nuc_pkg::OFS_CONTROL_STATUS, c, nuc_pkg::RESP_OKAY);
         done(14'($urandom));
         c = c & 8'hfd & (op == nuc_pkg::NUC_OP_ERASE ? 8'hef : 8'hff);
         rd(nuc_pkg::OFS_CONTROL_STATUS, 8'hf7, nuc_pkg::RESP_OKAY, c);
      end
      // Broken unlock sequences and a missing enable are refused
      for (int i = 0; i < 4; i++) begin
         wr(nuc_pkg::OFS_CONTROL_STATUS, 8'h00, nuc_pkg::RESP_OKAY);
         if (i == 1) wr(nuc_pkg::OFS_UNLOCK_KEY, 8'haa, nuc_pkg::RESP_OKAY);
         if (i != 0) wr(nuc_pkg::OFS_UNLOCK_KEY, 8'h55, nuc_pkg::RESP_OKAY);
         if (i == 2) wr(nuc_pkg::OFS_ADDRESS_LOW, al, nuc_pkg::RESP_OKAY);
         if (i >= 2) wr(nuc_pkg::OFS_UNLOCK_KEY, 8'haa, nuc_pkg::RESP_OKAY);
         c = (i == 3) ? 8'h82 : 8'h86;
         wr(nuc_pkg::OFS_CONTROL_STATUS, c, nuc_pkg::RESP_OKAY);
         rd(nuc_pkg::OFS_CONTROL_STATUS, 8'h08, nuc_pkg::RESP_OKAY, '1);
      end
      // Read of a program word lands in the data bytes
      v = 14'($urandom);
      mq.push_back({1'b0, nuc_pkg::NUC_OP_READ, 2'b10, ah[6:0], al,
         dh[5:0], dl});
      wr(nuc_pkg::OFS_CONTROL_STATUS, 8'h81, nuc_pkg::RESP_OKAY);
      done(v);
      rd(nuc_pkg::OFS_DATA_LOW, '1, nuc_pkg::RESP_OKAY, v[7:0]);
      rd(nuc_pkg::OFS_DATA_HIGH, '1, nuc_pkg::RESP_OKAY, 8'(v[13:8]));
      repeat (4) @(posedge clock);
      if (mq.size() + rq.size() + bq.size() != 0) begin
         err_count++;
         $display("[FAIL] %0t expected results left over", $time);
      end
      close_out();
   end
endmodule // nuc_ctrl_tb_top
